// >>> inc/cfs_map.svh
`ifndef CFS_MAP_SVH
`define CFS_MAP_SVH
// ****************************************
// Clock and timing
// ****************************************
`define CFS_CLK_MHZ 250
`define CFS_OV_DELAY_NS 10000
`define CFS_OV_CYCLES ((`CFS_OV_DELAY_NS * `CFS_CLK_MHZ + 999) / 1000)
`define CFS_SS_NS 1000000
`define CFS_SS_CYCLES (`CFS_SS_NS * `CFS_CLK_MHZ / 1000)
`define CFS_HICCUP_PERIODS 3'h7
`define CFS_FALLBACK_PULSES 4'h8
`define CFS_KHZ_0 500
`define CFS_KHZ_1 1000
`define CFS_KHZ_2 1500
`define CFS_KHZ_3 2000
// ****************************************
// Register offsets
// ****************************************
`define CFS_REG_CTRL 8'h00
`define CFS_REG_STATUS 8'h04
`define CFS_REG_CONFIG 8'h08
`define CFS_REG_IRQ_STAT 8'h0c
`define CFS_REG_IRQ_MASK 8'h10
// ****************************************
// Fields and reset values
// ****************************************
`define CFS_CTRL_RUN 0
`define CFS_CTRL_RESET 1'h1
`define CFS_IRQ_OV 0
`define CFS_IRQ_UV 1
`define CFS_IRQ_THERMAL 2
`define CFS_IRQ_SYNC_LOST 3
`define CFS_IRQ_SS_DONE 4
`define CFS_IRQ_MASK_RESET 5'h00
`define CFS_PHASE_TWO 4'h0
`define CFS_PHASE_A_LAST 4'h4
`define CFS_PHASE_B_LAST 4'h8
`endif

// >>> inc/cfs_pkg.sv
package cfs_pkg;
	typedef enum logic [2:0] {ST_OFF, ST_SOFT, ST_RUN, ST_HICCUP, ST_THERMAL} cfs_fsm_t;
	typedef enum logic [1:0] {PH_0, PH_90, PH_180, PH_270} cfs_phase_t;
	typedef struct packed {
		logic dualOutput;
		cfs_phase_t ch1Phase;
		cfs_phase_t ch2Phase;
		logic [1:0] ramp2Sel;
		logic [1:0] freqSel;
		logic [1:0] ramp1Sel;
	} cfs_cfg_t;
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} cfs_wb_req_t;
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} cfs_wb_rsp_t;
	typedef struct packed {
		logic overVolt;
		logic underVolt;
		logic overTemp;
		logic tempRecovered;
		logic softStartDone;
	} cfs_sense_t;
endpackage

// >>> design/cfs_supervisor.sv
// How it works
// - Feedback above overvoltage level for 10 us stops switching and enters hiccup.
// - After overvoltage hiccup entry, wait seven soft-start periods, then restart.
// - Overvoltage watch is live during soft start and afterwards.
// - Feedback below undervoltage level enters hiccup with seven soft-start periods wait.
// - Undervoltage watch is ignored until soft start has finished.
// - Junction temperature over the trip level halts conversion.
// - After thermal halt, restart only once temperature fell by the hysteresis.
// - Lost sync runs at 75 percent frequency for eight cycles, then free-running.
// - Dual phase with external clock switches at the sync input frequency.
// - Dual phase with external clock takes channel phasing from the phase strap.
// - Frequency strap sets frequency and output one ramp; phase strap sets phase, output two.
// - Phase code 10.7 k selects two-phase with channels at 0 and 180 degrees.
// - Codes 15.4 to 22.1 k select dual outputs at 0/180 with four ramps.
// - Codes 24.9 to 38.3 k select dual outputs at 90/270 with four ramps.
// - Dual outputs use a fixed internal one millisecond soft start.
`include "cfs_map.svh"
`default_nettype none
module cfs_supervisor #(
	parameter int SS_CYCLES = `CFS_SS_CYCLES
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic enable,
	input wire cfs_pkg::cfs_sense_t sense,
	input wire logic syncIn,
	input wire logic [3:0] phaseStrapCode,
	input wire logic [3:0] frequencyStrapCode,
	input wire cfs_pkg::cfs_wb_req_t wbReq,
	output cfs_pkg::cfs_wb_rsp_t wbRsp,
	output logic switchEn,
	output logic ch1Clk,
	output logic ch2Clk,
	output cfs_pkg::cfs_cfg_t cfg,
	output logic syncLocked,
	output logic irq
);
	import cfs_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		cfs_fsm_t fsm;
		logic [11:0] ovCnt;
		logic [17:0] ssCnt;
		logic [2:0] hicCnt;
		cfs_cfg_t cfg;
		logic syncPrev;
		logic locked;
		logic [3:0] fallCnt;
		logic [10:0] divCnt;
		logic ch1Clk;
		logic ch2Clk;
		logic run;
		logic [4:0] irqStat;
		logic [4:0] irqMask;
		logic ack;
		logic [31:0] dat;
	} cfs_state_t;

	cfs_state_t state_ff;
	cfs_state_t nxt_state;

	localparam logic [11:0] OV_LAST = 12'(`CFS_OV_CYCLES - 1);
	localparam logic [17:0] SS_LAST = 18'(SS_CYCLES - 1);

	// Switching period in system cycles for each frequency strap group.
	function automatic logic [10:0] basePeriod(input logic [1:0] f);
		case (f)
			2'h0: basePeriod = 11'(`CFS_CLK_MHZ * 1000 / `CFS_KHZ_0);
			2'h1: basePeriod = 11'(`CFS_CLK_MHZ * 1000 / `CFS_KHZ_1);
			2'h2: basePeriod = 11'(`CFS_CLK_MHZ * 1000 / `CFS_KHZ_2);
			default: basePeriod = 11'(`CFS_CLK_MHZ * 1000 / `CFS_KHZ_3);
		endcase
	endfunction

	// Strap decode; codes above the last printed one fall back to the 0/180 dual group.
	function automatic cfs_cfg_t decode(input logic [3:0] p, input logic [3:0] f);
		decode.freqSel = f[3:2];
		decode.ramp1Sel = f[1:0];
		if (p == `CFS_PHASE_TWO) begin
			decode.dualOutput = 1'b0;
			decode.ch1Phase = PH_0;
			decode.ch2Phase = PH_180;
			decode.ramp2Sel = 2'h0;
		end else if (p > `CFS_PHASE_A_LAST && p <= `CFS_PHASE_B_LAST) begin
			decode.dualOutput = 1'b1;
			decode.ch1Phase = PH_90;
			decode.ch2Phase = PH_270;
			decode.ramp2Sel = 2'(p - 4'h5);
		end else begin
			decode.dualOutput = 1'b1;
			decode.ch1Phase = PH_0;
			decode.ch2Phase = PH_180;
			decode.ramp2Sel = 2'(p - 4'h1);
		end
	endfunction

	logic [10:0] period;
	logic [10:0] runPeriod;
	logic [10:0] offs1;
	logic [10:0] offs2;
	logic syncEdge;
	logic ssDone;
	logic ssWrap;
	logic [4:0] evt;
	logic [4:0] clr;
	logic wbHit;
	logic [31:0] rdData;

	always_comb begin
		nxt_state = state_ff;
		evt = 5'h00;
		clr = 5'h00;
		rdData = 32'h0000_0000;
		period = basePeriod(state_ff.cfg.freqSel);
		// Fallback stretches the period by four thirds, giving 75 percent of the rate.
		runPeriod = (state_ff.fallCnt != 4'h0) ? 11'((period * 4) / 3) : period;
		offs1 = 11'((period >> 2) * state_ff.cfg.ch1Phase);
		offs2 = 11'((period >> 2) * state_ff.cfg.ch2Phase);
		syncEdge = syncIn & ~state_ff.syncPrev;
		ssWrap = (state_ff.ssCnt == SS_LAST);
		// Multiphase soft start is timed outside; dual outputs use the fixed internal ramp.
		ssDone = state_ff.cfg.dualOutput ? ssWrap : sense.softStartDone;
		wbHit = wbReq.cyc & wbReq.stb & ~state_ff.ack;

		// ****************************************
		// Switching clock and sync tracking
		// ****************************************
		nxt_state.syncPrev = syncIn;
		if (syncEdge) begin
			// A sync edge restarts the divider, so the sync input sets the rate.
			nxt_state.divCnt = 11'h000;
			nxt_state.locked = 1'b1;
			nxt_state.fallCnt = 4'h0;
		end else if (state_ff.locked && state_ff.divCnt >= 11'(period * 2 - 1)) begin
			// Two silent periods count as a lost external clock.
			nxt_state.locked = 1'b0;
			nxt_state.fallCnt = `CFS_FALLBACK_PULSES;
			nxt_state.divCnt = 11'h000;
			evt[`CFS_IRQ_SYNC_LOST] = 1'b1;
		end else if (!state_ff.locked && state_ff.divCnt >= runPeriod - 11'h001) begin
			nxt_state.divCnt = 11'h000;
			if (state_ff.fallCnt != 4'h0) begin
				nxt_state.fallCnt = state_ff.fallCnt - 4'h1;
			end
		end else begin
			nxt_state.divCnt = state_ff.divCnt + 11'h001;
		end
		nxt_state.ch1Clk = (state_ff.divCnt == offs1);
		nxt_state.ch2Clk = (state_ff.divCnt == offs2);

		// ****************************************
		// Fault sequencer
		// ****************************************
		nxt_state.ssCnt = ssWrap ? 18'h00000 : state_ff.ssCnt + 18'h00001;
		case (state_ff.fsm)
			ST_OFF: begin
				nxt_state.ssCnt = 18'h00000;
				if (enable && state_ff.run) begin
					nxt_state.cfg = decode(phaseStrapCode, frequencyStrapCode);
					nxt_state.fsm = ST_SOFT;
				end
			end
			ST_SOFT: begin
				if (ssDone) begin
					nxt_state.fsm = ST_RUN;
					evt[`CFS_IRQ_SS_DONE] = 1'b1;
				end
			end
			ST_RUN: begin
				if (sense.underVolt) begin
					nxt_state.fsm = ST_HICCUP;
					nxt_state.ssCnt = 18'h00000;
					nxt_state.hicCnt = 3'h0;
					evt[`CFS_IRQ_UV] = 1'b1;
				end
			end
			ST_HICCUP: begin
				if (ssWrap) begin
					nxt_state.hicCnt = state_ff.hicCnt + 3'h1;
					if (state_ff.hicCnt == `CFS_HICCUP_PERIODS - 3'h1) begin
						nxt_state.fsm = ST_SOFT;
					end
				end
			end
			ST_THERMAL: begin
				if (sense.tempRecovered) begin
					nxt_state.fsm = ST_SOFT;
					nxt_state.ssCnt = 18'h00000;
				end
			end
			default: nxt_state.fsm = ST_OFF;
		endcase

		// Overvoltage must persist for the full qualification window.
		if ((state_ff.fsm == ST_SOFT || state_ff.fsm == ST_RUN) && sense.overVolt) begin
			nxt_state.ovCnt = state_ff.ovCnt + 12'h001;
			if (state_ff.ovCnt == OV_LAST) begin
				nxt_state.fsm = ST_HICCUP;
				nxt_state.ssCnt = 18'h00000;
				nxt_state.hicCnt = 3'h0;
				nxt_state.ovCnt = 12'h000;
				evt[`CFS_IRQ_OV] = 1'b1;
			end
		end else begin
			nxt_state.ovCnt = 12'h000;
		end

		// Thermal trip overrides every other fault while the part is enabled.
		if (state_ff.fsm != ST_OFF && state_ff.fsm != ST_THERMAL && sense.overTemp) begin
			nxt_state.fsm = ST_THERMAL;
			nxt_state.ovCnt = 12'h000;
			evt[`CFS_IRQ_THERMAL] = 1'b1;
		end
		if (!enable || !state_ff.run) begin
			nxt_state.fsm = ST_OFF;
			nxt_state.ovCnt = 12'h000;
		end

		// ****************************************
		// Wishbone slave
		// ****************************************
		case (wbReq.adr)
			`CFS_REG_CTRL: rdData = {31'h0, state_ff.run};
			`CFS_REG_STATUS: rdData = {24'h0, 3'h0, state_ff.fallCnt != 4'h0, state_ff.locked, state_ff.fsm};
			`CFS_REG_CONFIG: rdData = {21'h0, state_ff.cfg};
			`CFS_REG_IRQ_STAT: rdData = {27'h0, state_ff.irqStat};
			`CFS_REG_IRQ_MASK: rdData = {27'h0, state_ff.irqMask};
			default: rdData = 32'h0000_0000;
		endcase
		nxt_state.ack = wbHit;
		if (wbHit && !wbReq.we) begin
			nxt_state.dat = rdData;
		end
		if (wbHit && wbReq.we && wbReq.sel[0]) begin
			case (wbReq.adr)
				`CFS_REG_CTRL: nxt_state.run = wbReq.dat[`CFS_CTRL_RUN];
				`CFS_REG_IRQ_STAT: clr = wbReq.dat[4:0];
				`CFS_REG_IRQ_MASK: nxt_state.irqMask = wbReq.dat[4:0];
				default: ;
			endcase
		end
		// A new event in the clearing cycle keeps its bit set.
		nxt_state.irqStat = (state_ff.irqStat & ~clr) | evt;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_ff <= '0;
			state_ff.fsm <= ST_OFF;
			state_ff.run <= `CFS_CTRL_RESET;
			state_ff.irqMask <= `CFS_IRQ_MASK_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign wbRsp.ack = state_ff.ack;
	assign wbRsp.dat = state_ff.dat;
	assign switchEn = (state_ff.fsm == ST_SOFT) || (state_ff.fsm == ST_RUN);
	assign ch1Clk = state_ff.ch1Clk;
	assign ch2Clk = state_ff.ch2Clk;
	assign cfg = state_ff.cfg;
	assign syncLocked = state_ff.locked;
	assign irq = |(state_ff.irqStat & state_ff.irqMask);
endmodule // cfs_supervisor
`default_nettype wire

// >>> tb/cfs_sync_src.sv
`default_nettype none
module cfs_sync_src (
	input wire logic clk,
	input wire logic run,
	input wire logic [15:0] per,
	output logic syncOut
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] cnt_ff = 16'h0000;
	initial syncOut = 1'b0;
	// The source stops dead when switched off, so the device really sees the clock vanish.
	always @(posedge clk) begin
		cnt_ff <= (run && cnt_ff < per - 16'h0001) ? cnt_ff + 16'h0001 : 16'h0000;
		syncOut <= run && cnt_ff < (per >> 1);
	end
endmodule // cfs_sync_src
`default_nettype wire

// >>> tb/cfs_supervisor_chk.sv
`default_nettype none
module cfs_supervisor_chk #(
	parameter int SS_CYCLES = 200
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic enable,
	input wire cfs_pkg::cfs_sense_t sense,
	input wire cfs_pkg::cfs_wb_req_t wbReq,
	input wire cfs_pkg::cfs_wb_rsp_t wbRsp,
	input wire logic switchEn,
	input wire cfs_pkg::cfs_cfg_t cfg
);
	import cfs_pkg::*;
	localparam int OV_N = 2500;
	logic [11:0] ovCnt_ff;
	logic [19:0] onCnt_ff;
	always_ff @(posedge sys_clk) begin
		ovCnt_ff <= (sys_rst || !(sense.overVolt && switchEn)) ? 12'h000 : ovCnt_ff + 12'h001;
		onCnt_ff <= (sys_rst || !switchEn) ? 20'h00000 : onCnt_ff + 20'h00001;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	property p_ackNext; wbReq.cyc && wbReq.stb && !wbRsp.ack |=> wbRsp.ack; endproperty
	a_ackNext: assert property (p_ackNext) else $error("ack missing");
	property p_ackOne; wbRsp.ack |=> !wbRsp.ack; endproperty
	a_ackOne: assert property (p_ackOne) else $error("ack too long");
	property p_ovHold;
		ovCnt_ff < OV_N - 2 && switchEn && enable && !sense.underVolt && !sense.overTemp |=> switchEn;
	endproperty
	a_ovHold: assert property (p_ovHold) else $error("early overvoltage stop");
	property p_ovTrip; ovCnt_ff < 12'(OV_N + 3); endproperty
	a_ovTrip: assert property (p_ovTrip) else $error("late overvoltage stop");
	property p_thermal; sense.overTemp |=> !switchEn; endproperty
	a_thermal: assert property (p_thermal) else $error("hot but switching");
	property p_uvSoft;
		switchEn && cfg.dualOutput && sense.underVolt && onCnt_ff < SS_CYCLES - 4 && enable && !sense.overTemp
			|=> switchEn;
	endproperty
	a_uvSoft: assert property (p_uvSoft) else $error("undervoltage acted in soft start");
	property p_uvRun; switchEn && cfg.dualOutput && sense.underVolt && onCnt_ff > SS_CYCLES + 4 |=> !switchEn; endproperty
	a_uvRun: assert property (p_uvRun) else $error("undervoltage ignored");
	property p_cfgHold; switchEn && $past(switchEn) |-> $stable(cfg); endproperty
	a_cfgHold: assert property (p_cfgHold) else $error("config moved while running");
	c_ovTrip: cover property (ovCnt_ff == OV_N - 1);
	c_uvRun: cover property (sense.underVolt && switchEn && onCnt_ff == SS_CYCLES + 5);
	c_ack: cover property (wbRsp.ack);
endmodule // cfs_supervisor_chk
bind cfs_supervisor cfs_supervisor_chk #(.SS_CYCLES(SS_CYCLES)) chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.enable(enable), .sense(sense), .wbReq(wbReq), .wbRsp(wbRsp), .switchEn(switchEn), .cfg(cfg));
`default_nettype wire

// >>> tb/cfs_supervisor_tb.sv
`include "cfs_map.svh"
`default_nettype none
module cfs_supervisor_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cfs_pkg::*;
	localparam int SS = 200;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic enable = 1'b0;
	logic syncRun = 1'b0;
	logic syncIn, switchEn, ch1Clk, ch2Clk, syncLocked, irq;
	logic [3:0] phaseStrapCode = 4'h0;
	logic [3:0] frequencyStrapCode = 4'h0;
	logic [31:0] rd;
	logic [10:0] expCfg, msk;
	cfs_sense_t sense = '0;
	cfs_wb_req_t wbReq = '0;
	cfs_wb_rsp_t wbRsp;
	cfs_cfg_t cfg;
	int mismatches = 0;
	int checks = 0;
	int n;
	cfs_supervisor #(.SS_CYCLES(SS)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .enable(enable), .sense(sense),
		.syncIn(syncIn), .phaseStrapCode(phaseStrapCode), .frequencyStrapCode(frequencyStrapCode), .wbReq(wbReq),
		.wbRsp(wbRsp), .switchEn(switchEn), .ch1Clk(ch1Clk), .ch2Clk(ch2Clk), .cfg(cfg),
		.syncLocked(syncLocked), .irq(irq));
	cfs_sync_src src (.clk(sys_clk), .run(syncRun), .per(16'h0104), .syncOut(syncIn));
	initial forever #2 sys_clk = ~sys_clk;
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s exp %h got %h", what, e, g);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int t = 0;
		@(posedge sys_clk);
		wbReq <= '{1'b1, 1'b1, we, a, 4'hf, d};
		do begin
			@(posedge sys_clk);
			t++;
		end while (wbRsp.ack !== 1'b1 && t < 50);
		rd = wbRsp.dat;
		wbReq <= '0;
		if (wbRsp.ack !== 1'b1) begin
			cmp("ack", 32'h1, 32'(wbRsp.ack));
			close_out();
		end
	endtask
	// Waits sample on the falling edge so the design's updates have landed.
	task automatic waitFor(ref logic s, input logic v, input int lim);
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (s !== v && n < lim);
		if (s !== v) begin
			cmp("wait", 32'(v), 32'(s));
			close_out();
		end
	endtask
	initial begin
		repeat (8) @(posedge sys_clk);
		sys_rst <= 1'b0;
		wb(1'b0, `CFS_REG_CTRL, 32'h0);
		cmp("ctrl", 32'h1, rd);
		wb(1'b0, `CFS_REG_IRQ_MASK, 32'h0);
		cmp("mask", 32'h0, rd);
		wb(1'b1, 8'h14, 32'hffffffff);
		wb(1'b0, 8'h14, 32'h0);
		cmp("unmapped", 32'h0, rd);
		$display("test registers done");
		for (int c = 0; c < 9; c++) begin
			@(posedge sys_clk);
			phaseStrapCode <= 4'(c);
			frequencyStrapCode <= 4'(15 - c);
			enable <= 1'b1;
			waitFor(switchEn, 1'b1, 10);
			expCfg = {c != 0, c < 5 ? PH_0 : PH_90, c < 5 ? PH_180 : PH_270, 2'(c - 1), 4'(15 - c)};
			msk = (c == 0) ? 11'h7cf : 11'h7ff;
			cmp("cfg", 32'(expCfg & msk), 32'(cfg & msk));
			@(posedge sys_clk);
			phaseStrapCode <= 4'h7;
			repeat (3) @(negedge sys_clk);
			cmp("cfg held", 32'(expCfg & msk), 32'(cfg & msk));
			@(posedge sys_clk);
			enable <= 1'b0;
			waitFor(switchEn, 1'b0, 10);
		end
		$display("test straps done");
		@(posedge sys_clk);
		phaseStrapCode <= 4'h1;
		frequencyStrapCode <= 4'h4;
		enable <= 1'b1;
		sense.overVolt <= 1'b1;
		// Switching only starts one edge after enable, so wait for it before timing the trip.
		waitFor(switchEn, 1'b1, 10);
		waitFor(switchEn, 1'b0, 2600);
		cmp("ov delay", 32'h1, 32'(n > 2498 && n < 2505));
		@(posedge sys_clk);
		sense.overVolt <= 1'b0;
		waitFor(switchEn, 1'b1, 1500);
		cmp("ov wait", 32'h1, 32'(n > 7 * SS - 4 && n < 7 * SS + 2));
		wb(1'b0, `CFS_REG_IRQ_STAT, 32'h0);
		cmp("ov flag", 32'h1, 32'(rd[`CFS_IRQ_OV]));
		wb(1'b1, `CFS_REG_IRQ_MASK, 32'h1);
		@(negedge sys_clk);
		cmp("irq on", 32'h1, 32'(irq));
		wb(1'b1, `CFS_REG_IRQ_STAT, 32'h1);
		@(negedge sys_clk);
		cmp("irq off", 32'h0, 32'(irq));
		$display("test overvoltage done");
		@(posedge sys_clk);
		sense.underVolt <= 1'b1;
		repeat (100) @(negedge sys_clk);
		cmp("uv soft", 32'h1, 32'(switchEn));
		waitFor(switchEn, 1'b0, 150);
		wb(1'b0, `CFS_REG_STATUS, 32'h0);
		cmp("uv state", 32'h3, 32'(rd[2:0]));
		@(posedge sys_clk);
		sense.underVolt <= 1'b0;
		waitFor(switchEn, 1'b1, 1500);
		$display("test undervoltage done");
		@(posedge sys_clk);
		sense.overTemp <= 1'b1;
		repeat (2) @(negedge sys_clk);
		cmp("hot stop", 32'h0, 32'(switchEn));
		@(posedge sys_clk);
		sense.overTemp <= 1'b0;
		repeat (50) @(negedge sys_clk);
		wb(1'b0, `CFS_REG_STATUS, 32'h0);
		cmp("hot hold", 32'h4, 32'(rd[2:0]));
		@(posedge sys_clk);
		sense.tempRecovered <= 1'b1;
		waitFor(switchEn, 1'b1, 10);
		$display("test thermal done");
		@(posedge sys_clk);
		syncRun <= 1'b1;
		repeat (3) waitFor(ch1Clk, 1'b1, 400);
		cmp("sync period", 32'd260, 32'(n));
		cmp("locked", 32'h1, 32'(syncLocked));
		@(posedge sys_clk);
		syncRun <= 1'b0;
		waitFor(syncLocked, 1'b0, 800);
		repeat (2) waitFor(ch1Clk, 1'b1, 400);
		cmp("fallback period", 32'd333, 32'(n));
		repeat (10) waitFor(ch1Clk, 1'b1, 400);
		cmp("free period", 32'd250, 32'(n));
		waitFor(ch2Clk, 1'b1, 400);
		cmp("ch2 offset", 32'd124, 32'(n));
		$display("test sync done");
		close_out();
	end
endmodule // cfs_supervisor_tb
`default_nettype wire
